//--- cie_pkg.sv
// Shared constants, types and helpers of the instruction-execute core.
package cie_pkg;
	localparam logic [15:0] PC_RESET       = 16'h0000;
	localparam logic [15:0] SP_RESET       = 16'h04FF;
	localparam logic [7:0]  STATUS_FLAGS_REGISTER_RESET     = 8'h00;
	localparam logic [15:0] IO_DATA_OFFSET = 16'h0020;
	localparam logic [15:0] IO_BIT_LIMIT   = 16'h0040;
	localparam logic [15:0] IO_PORT_LAST   = 16'h005F;
	localparam logic [15:0] ONE_WORD       = 16'h0001;
	localparam logic [15:0] TWO_WORDS      = 16'h0002;
	localparam logic [4:0]  REG_R0         = 5'h00;
	localparam logic [4:0]  REG_R1         = 5'h01;
	localparam logic [4:0]  REG_ZL         = 5'h1E;
	localparam logic [4:0]  REG_ZH         = 5'h1F;
	localparam logic [15:0] OP_PTR_JUMP    = 16'h9409;
	localparam logic [15:0] OP_PTR_CALL    = 16'h9509;
	localparam int          FLAG_C         = 0;
	localparam int          FLAG_Z         = 1;
	localparam int          FLAG_N         = 2;
	localparam int          FLAG_V         = 3;
	localparam int          FLAG_S         = 4;
	localparam int          FLAG_H         = 5;
	localparam logic [3:0]  ALU_CPC        = 4'h1;
	localparam logic [3:0]  ALU_SBC        = 4'h2;
	localparam logic [3:0]  ALU_ADD        = 4'h3;
	localparam logic [3:0]  ALU_CP         = 4'h5;
	localparam logic [3:0]  ALU_SUB        = 4'h6;
	localparam logic [3:0]  ALU_ADC        = 4'h7;
	localparam logic [3:0]  ALU_AND        = 4'h8;
	localparam logic [3:0]  ALU_EOR        = 4'h9;
	localparam logic [3:0]  ALU_OR         = 4'hA;

	typedef enum logic [2:0] {ST_EXEC, ST_STALL, ST_SKIP, ST_OPER, ST_PUSH} cie_state_e;
	typedef enum logic [2:0] {OP_ADD, OP_SUB, OP_AND, OP_OR, OP_EOR} cie_alu_op_e;

	// Direct load, store, jump and call carry a second word.
	function automatic logic is_two_word(input logic [15:0] w);
		return ((w[15:10] == 6'h24) && (w[3:0] == 4'h0))
			|| ((w[15:9] == 7'h4A) && (w[3:2] == 2'h3));
	endfunction

	// I/O numbers sit above the register file in data space.
	function automatic logic [15:0] io_to_data(input logic [5:0] a);
		return {10'h000, a} + IO_DATA_OFFSET;
	endfunction
endpackage

//--- cie_alu.sv
// Byte adder, subtractor and logic unit with its flag outputs.
module cie_alu (
	// Operation and operands
	input  wire cie_pkg::cie_alu_op_e op,
	input  wire logic [7:0]           a,
	input  wire logic [7:0]           b,
	input  wire logic                 cin,
	// Result and flags
	output logic [7:0]                res,
	output logic                      hf,
	output logic                      vf,
	output logic                      nf,
	output logic                      zf,
	output logic                      cf
);
	logic [8:0] sum;
	logic [4:0] nib;

	always_comb
	begin
		sum = {1'b0, a} + {1'b0, b} + {8'h00, cin};
		nib = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
		vf = 1'b0;
		if (op == cie_pkg::OP_SUB)
		begin
			sum = {1'b0, a} - {1'b0, b} - {8'h00, cin};
			nib = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, cin};
		end
		res = sum[7:0];
		case (op)
		cie_pkg::OP_ADD: vf = (a[7] == b[7]) && (res[7] != a[7]);
		cie_pkg::OP_SUB: vf = (a[7] != b[7]) && (res[7] != a[7]);
		cie_pkg::OP_AND: res = a & b;
		cie_pkg::OP_OR:  res = a | b;
		cie_pkg::OP_EOR: res = a ^ b;
		default: res = sum[7:0];
		endcase
		hf = nib[4];
		cf = sum[8];
	end

	assign nf = res[7];
	assign zf = (res == 8'h00);
endmodule

//--- cie_mul.sv
// Combinational byte multiplier covering signed, unsigned, mixed and fractional forms.
module cie_mul (
	// Operands and form
	input  wire logic [7:0] a,
	input  wire logic [7:0] b,
	input  wire logic       a_signed,
	input  wire logic       b_signed,
	input  wire logic       frac,
	// Product and flags
	output logic [15:0]     prod,
	output logic            zf,
	output logic            cf
);
	logic signed [8:0]  ax;
	logic signed [8:0]  bx;
	logic signed [17:0] full;

	assign ax = {a_signed & a[7], a};
	assign bx = {b_signed & b[7], b};
	assign full = ax * bx;
	// Carry takes the top bit before the fractional shift drops it.
	assign cf = full[15];
	assign prod = frac ? {full[14:0], 1'b0} : full[15:0];
	assign zf = (prod == 16'h0000);
endmodule

//--- cie_core.sv
// Instruction-execute core: decode, register file, flags, program counter and data bus.
// Function
// RULE1: Add two registers, optionally with carry, set Z C N V H, one cycle.
// RULE2: Add or subtract constant on a register pair, set Z C N V S, two cycles.
// RULE3: Subtract register or constant, optionally with borrow, set Z C N V H, one cycle.
// RULE4: AND, OR, exclusive-OR set only Z N V and take one cycle; the code also updates S.
// RULE5: Set-mask ORs a constant in; clear-mask ANDs with the complemented mask.
// RULE6: Zero-minus test ANDs a register with itself, value unchanged, sets Z N V.
// RULE7: Byte multiplies put the product in R1:R0, set Z C, two cycles.
// RULE8: Fractional multiplies shift the product left once before storing, two cycles.
// RULE9: Pointer jump loads the program counter from Z in two cycles, flags kept.
// RULE10: Pointer call saves the return address, jumps to Z, three cycles.
// RULE11: Compare with constant subtracts without storing, sets Z N V C H.
// RULE12: Compare-skip-equal skips the next instruction when both registers match.
// RULE13: Register bit skips test one bit and skip the next instruction.
// RULE14: I/O bit skips test one I/O bit and skip the next instruction.
// RULE15: Flag branches jump to PC plus offset plus one, one or two cycles.
// RULE16: Signed branches test N XOR V, taken at 0 for ge, 1 for lt.
// RULE17: Unsigned branches test carry, same as carry-clear and carry-set branches.
// RULE18: Bit set, clear and bit skips reach only I/O locations 0x00 to 0x1F.
// RULE19: Bit set and clear touch only the addressed bit.
// RULE20: Port access uses I/O 0x00 to 0x3F; data space adds 0x20.
// RULE21: Extended I/O 0x60 to 0xFF is reached only by data-space loads and stores.
// RULE22: Software writes reserved bits as zero and never writes reserved addresses.
// RULE23: Absolute jump and call run only on the largest program memory variant.
// RULE24: A taken skip passes over one or two words, costing two or three cycles.
module cie_core #(
	parameter bit          LARGE_PM = 1'b1,
	parameter logic [15:0] SP_INIT  = cie_pkg::SP_RESET
) (
	// Clock, reset and clock enable
	input  wire logic        sys_clk,
	input  wire logic        sys_rst,
	input  wire logic        ce,
	// Program memory, word valid in the same cycle
	output logic [15:0]      pm_addr,
	input  wire logic [15:0] pm_data,
	// Data space bus, read data valid in the same cycle
	output logic [15:0]      dbus_addr,
	output logic             dbus_re,
	output logic             dbus_we,
	output logic [7:0]       dbus_wdata,
	output logic [7:0]       dbus_wmask,
	input  wire logic [7:0]  dbus_rdata,
	// Status
	output logic [7:0]       status_flags
);
	cie_pkg::cie_state_e  state_q;
	cie_pkg::cie_state_e  state_d;
	cie_pkg::cie_alu_op_e alu_op;
	logic [15:0]          pc_q, pc_d, sp_q, sp_d, tgt_q, tgt_d, ir_q, ir_d;
	logic [15:0]          zptr, ret_addr, wv, wres, k6, prod, br_target, rj_target;
	logic [7:0]           status_flags_register_q, status_flags_register_d, rd_val, rr_val, k8, alu_b, alu_res;
	logic [7:0]           wd1, wd2, bit_mask;
	logic [7:0]           rf_q [32];
	logic [4:0]           rd_sel, rr_sel, wa1, wa2;
	logic [3:0]           alu_code;
	logic [2:0]           bit_sel;
	logic                 we1, we2, alu_use_c, alu_store, alu_logic, use_imm;
	logic                 alu_h, alu_v, alu_n, alu_z, alu_c, mul_z, mul_c;
	logic                 mul_sa, mul_sb, mul_fr, br_taken, push_lo, skip_if;
	logic                 fl_arith, fl_logic, fl_word, fl_mul, fl_branch, fl_bitio, fl_port;

	assign pm_addr = pc_q;
	assign status_flags = status_flags_register_q;
	assign rd_val = rf_q[rd_sel];
	assign rr_val = rf_q[rr_sel];
	assign k8 = {pm_data[11:8], pm_data[3:0]};
	assign k6 = {10'h000, pm_data[7:6], pm_data[3:0]};
	assign bit_sel = pm_data[2:0];
	assign bit_mask = 8'h01 << bit_sel;
	assign zptr = {rf_q[cie_pkg::REG_ZH], rf_q[cie_pkg::REG_ZL]};
	assign ret_addr = pc_q + cie_pkg::ONE_WORD;
	assign wv = {rf_q[rd_sel + 5'h01], rd_val};
	assign wres = pm_data[8] ? (wv - k6) : (wv + k6);
	assign br_taken = (status_flags_register_q[bit_sel] != pm_data[10]);
	assign br_target = pc_q + {{9{pm_data[9]}}, pm_data[9:3]} + cie_pkg::ONE_WORD;
	assign rj_target = pc_q + {{4{pm_data[11]}}, pm_data[11:0]} + cie_pkg::ONE_WORD;

	// Register selection per encoding; the operand word of a direct access names ir_q.
	always_comb
	begin
		rd_sel = pm_data[8:4];
		rr_sel = {pm_data[9], pm_data[3:0]};
		use_imm = pm_data[14] || (pm_data[15:12] == 4'h3);
		if (use_imm && !pm_data[15])
			rd_sel = {1'b1, pm_data[7:4]};
		if (pm_data[15:12] == 4'hE)
			rd_sel = {1'b1, pm_data[7:4]};
		if (pm_data[15:9] == 7'h4B)
			rd_sel = {2'h3, pm_data[5:4], 1'b0};
		if (pm_data[15:8] == 8'h02)
		begin
			rd_sel = {1'b1, pm_data[7:4]};
			rr_sel = {1'b1, pm_data[3:0]};
		end
		if (pm_data[15:8] == 8'h03)
		begin
			rd_sel = {2'h2, pm_data[6:4]};
			rr_sel = {2'h2, pm_data[2:0]};
		end
		if (state_q == cie_pkg::ST_OPER)
			rd_sel = ir_q[8:4];
	end

	// Immediate forms fold onto their register twins so one table serves both.
	always_comb
	begin
		alu_code = pm_data[13:10];
		case (pm_data[15:12])
		4'h3: alu_code = cie_pkg::ALU_CP;
		4'h4: alu_code = cie_pkg::ALU_SBC;
		4'h5: alu_code = cie_pkg::ALU_SUB;
		4'h6: alu_code = cie_pkg::ALU_OR; // RULE5
		4'h7: alu_code = cie_pkg::ALU_AND; // RULE5
		default: alu_code = pm_data[13:10];
		endcase
		case (alu_code)
		cie_pkg::ALU_ADD, cie_pkg::ALU_ADC: alu_op = cie_pkg::OP_ADD;
		cie_pkg::ALU_AND: alu_op = cie_pkg::OP_AND;
		cie_pkg::ALU_EOR: alu_op = cie_pkg::OP_EOR;
		cie_pkg::ALU_OR: alu_op = cie_pkg::OP_OR;
		default: alu_op = cie_pkg::OP_SUB;
		endcase
		alu_use_c = (alu_code == cie_pkg::ALU_CPC) || (alu_code == cie_pkg::ALU_SBC)
			|| (alu_code == cie_pkg::ALU_ADC);
		alu_store = (alu_code != cie_pkg::ALU_CPC) && (alu_code != cie_pkg::ALU_CP); // RULE11
		alu_logic = (alu_op == cie_pkg::OP_AND) || (alu_op == cie_pkg::OP_OR)
			|| (alu_op == cie_pkg::OP_EOR);
		alu_b = use_imm ? k8 : rr_val;
	end

	cie_alu u_alu (
		.op  (alu_op),
		.a   (rd_val),
		.b   (alu_b),
		.cin (alu_use_c & status_flags_register_q[cie_pkg::FLAG_C]),
		.res (alu_res),
		.hf  (alu_h),
		.vf  (alu_v),
		.nf  (alu_n),
		.zf  (alu_z),
		.cf  (alu_c)
	);

	cie_mul u_mul (
		.a        (rd_val),
		.b        (rr_val),
		.a_signed (mul_sa),
		.b_signed (mul_sb),
		.frac     (mul_fr),
		.prod     (prod),
		.zf       (mul_z),
		.cf       (mul_c)
	);

	always_comb
	begin
		pc_d = pc_q;
		state_d = cie_pkg::ST_EXEC;
		status_flags_register_d = status_flags_register_q;
		sp_d = sp_q;
		tgt_d = tgt_q;
		ir_d = ir_q;
		we1 = 1'b0;
		we2 = 1'b0;
		wa1 = rd_sel;
		wa2 = rd_sel + 5'h01;
		wd1 = alu_res;
		wd2 = 8'h00;
		dbus_addr = 16'h0000;
		dbus_re = 1'b0;
		dbus_we = 1'b0;
		dbus_wdata = 8'h00;
		dbus_wmask = 8'hFF;
		mul_sa = 1'b0;
		mul_sb = 1'b0;
		mul_fr = 1'b0;
		push_lo = 1'b0;
		skip_if = 1'b0;
		fl_arith = 1'b0;
		fl_logic = 1'b0;
		fl_word = 1'b0;
		fl_mul = 1'b0;
		fl_branch = 1'b0;
		fl_bitio = 1'b0;
		fl_port = 1'b0;
		case (state_q)
		cie_pkg::ST_EXEC:
		begin
			pc_d = ret_addr;
			casez (pm_data)
			cie_pkg::OP_PTR_JUMP:
			begin
				pc_d = zptr; // RULE9
				state_d = cie_pkg::ST_STALL;
			end
			cie_pkg::OP_PTR_CALL:
			begin
				pc_d = pc_q;
				tgt_d = zptr; // RULE10
				push_lo = 1'b1;
			end
			16'b1001010?????11??:
			begin
				ir_d = pm_data;
				state_d = LARGE_PM ? cie_pkg::ST_OPER : cie_pkg::ST_EXEC;
				if (!LARGE_PM)
					pc_d = pc_q + cie_pkg::TWO_WORDS; // RULE23
			end
			16'b100100????????00:
			begin
				ir_d = pm_data;
				state_d = cie_pkg::ST_OPER;
			end
			16'b0001_00??_????_????:
				skip_if = (rd_val == rr_val); // RULE12
			16'b1111_11??_????_0???:
				skip_if = (rd_val[bit_sel] == pm_data[9]); // RULE13
			16'b1001_10?1_????_????:
			begin
				fl_bitio = 1'b1;
				dbus_re = 1'b1;
				dbus_addr = cie_pkg::io_to_data({1'b0, pm_data[7:3]}); // RULE18
				skip_if = (dbus_rdata[bit_sel] == pm_data[9]); // RULE14
			end
			16'b1001_10?0_????_????:
			begin
				fl_bitio = 1'b1;
				dbus_we = 1'b1;
				dbus_addr = cie_pkg::io_to_data({1'b0, pm_data[7:3]}); // RULE18
				dbus_wmask = bit_mask; // RULE19
				dbus_wdata = pm_data[9] ? bit_mask : 8'h00;
				state_d = cie_pkg::ST_STALL;
			end
			16'b1011_????_????_????:
			begin
				fl_port = 1'b1;
				dbus_addr = cie_pkg::io_to_data({pm_data[10:9], pm_data[3:0]}); // RULE20
				dbus_re = !pm_data[11];
				dbus_we = pm_data[11];
				dbus_wdata = rd_val;
				we1 = !pm_data[11];
				wd1 = dbus_rdata;
			end
			16'b1111_0???_????_????:
			begin
				fl_branch = 1'b1;
				if (br_taken)
				begin
					pc_d = br_target; // RULE15 RULE16 RULE17
					state_d = cie_pkg::ST_STALL;
				end
			end
			16'b1100_????_????_????:
			begin
				pc_d = rj_target;
				state_d = cie_pkg::ST_STALL;
			end
			16'b1001_011?_????_????:
			begin
				fl_word = 1'b1;
				we1 = 1'b1;
				we2 = 1'b1;
				wd1 = wres[7:0]; // RULE2
				wd2 = wres[15:8];
				state_d = cie_pkg::ST_STALL;
				status_flags_register_d[cie_pkg::FLAG_N] = wres[15];
				status_flags_register_d[cie_pkg::FLAG_Z] = (wres == 16'h0000);
				status_flags_register_d[cie_pkg::FLAG_V] = pm_data[8] ? (wv[15] & ~wres[15]) : (~wv[15] & wres[15]);
				status_flags_register_d[cie_pkg::FLAG_C] = pm_data[8] ? (wres[15] & ~wv[15]) : (~wres[15] & wv[15]);
				status_flags_register_d[cie_pkg::FLAG_S] = status_flags_register_d[cie_pkg::FLAG_N] ^ status_flags_register_d[cie_pkg::FLAG_V];
			end
			16'b1001_11??_????_????, 16'b0000_001?_????_????:
			begin
				fl_mul = 1'b1;
				mul_fr = !pm_data[10] && pm_data[8] && (pm_data[7] || pm_data[3]); // RULE8
				mul_sa = !pm_data[10] && !(!pm_data[7] && pm_data[3] && pm_data[8]);
				mul_sb = !pm_data[10] && !(pm_data[8] && (pm_data[3] || !pm_data[7]));
				we1 = 1'b1;
				we2 = 1'b1;
				wa1 = cie_pkg::REG_R0; // RULE7
				wa2 = cie_pkg::REG_R1;
				wd1 = prod[7:0];
				wd2 = prod[15:8];
				status_flags_register_d[cie_pkg::FLAG_Z] = mul_z;
				status_flags_register_d[cie_pkg::FLAG_C] = mul_c;
				state_d = cie_pkg::ST_STALL;
			end
			16'b1110_????_????_????:
			begin
				we1 = 1'b1;
				wd1 = k8;
			end
			16'b0000_01??_????_????, 16'b0000_1???_????_????, 16'b0001_01??_????_????,
			16'b0001_1???_????_????, 16'b0010_0???_????_????, 16'b0010_10??_????_????,
			16'b0011_????_????_????, 16'b01??_????_????_????:
			begin
				we1 = alu_store; // RULE1 RULE3 RULE6
				fl_arith = !alu_logic;
				fl_logic = alu_logic; // RULE4
			end
			default: pc_d = ret_addr;
			endcase
			if (skip_if)
				state_d = cie_pkg::ST_SKIP;
			if (fl_arith || fl_logic)
			begin
				status_flags_register_d[cie_pkg::FLAG_N] = alu_n;
				status_flags_register_d[cie_pkg::FLAG_V] = alu_v;
				status_flags_register_d[cie_pkg::FLAG_S] = alu_n ^ alu_v;
				status_flags_register_d[cie_pkg::FLAG_Z] = alu_z;
			end
			if (fl_arith)
			begin
				status_flags_register_d[cie_pkg::FLAG_H] = alu_h;
				status_flags_register_d[cie_pkg::FLAG_C] = alu_c;
				// Borrow-chained subtract and compare forms keep zero only if the earlier byte was zero too.
				if (alu_use_c && (alu_op == cie_pkg::OP_SUB))
					status_flags_register_d[cie_pkg::FLAG_Z] = alu_z & status_flags_register_q[cie_pkg::FLAG_Z];
			end
		end
		cie_pkg::ST_SKIP:
		begin
			pc_d = pc_q + (cie_pkg::is_two_word(pm_data) ? cie_pkg::TWO_WORDS
				: cie_pkg::ONE_WORD); // RULE24
			if (cie_pkg::is_two_word(pm_data))
				state_d = cie_pkg::ST_STALL;
		end
		cie_pkg::ST_OPER:
		begin
			pc_d = ret_addr;
			casez (ir_q)
			16'b1001010?????110?:
			begin
				pc_d = pm_data;
				state_d = cie_pkg::ST_STALL;
			end
			16'b1001010?????111?:
			begin
				pc_d = pc_q;
				tgt_d = pm_data;
				push_lo = 1'b1;
			end
			16'b1001_000?_????_????:
			begin
				dbus_re = 1'b1;
				dbus_addr = pm_data; // RULE21
				we1 = 1'b1;
				wd1 = dbus_rdata;
			end
			default:
			begin
				dbus_we = 1'b1;
				dbus_addr = pm_data; // RULE21
				dbus_wdata = rd_val;
			end
			endcase
		end
		cie_pkg::ST_PUSH:
		begin
			dbus_we = 1'b1;
			dbus_addr = sp_q;
			dbus_wdata = ret_addr[15:8];
			sp_d = sp_q - cie_pkg::ONE_WORD;
			pc_d = tgt_q; // RULE10
			state_d = cie_pkg::ST_STALL;
		end
		default: state_d = cie_pkg::ST_EXEC;
		endcase
		// The low return byte goes first so the high byte ends on top of the stack.
		if (push_lo)
		begin
			dbus_we = 1'b1;
			dbus_addr = sp_q;
			dbus_wdata = ret_addr[7:0];
			sp_d = sp_q - cie_pkg::ONE_WORD;
			state_d = cie_pkg::ST_PUSH;
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			state_q <= cie_pkg::ST_EXEC;
			pc_q <= cie_pkg::PC_RESET;
		end
		else if (ce)
		begin
			state_q <= state_d;
			pc_q <= pc_d;
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			status_flags_register_q <= cie_pkg::STATUS_FLAGS_REGISTER_RESET;
			sp_q <= SP_INIT;
			tgt_q <= cie_pkg::PC_RESET;
			ir_q <= 16'h0000;
		end
		else if (ce)
		begin
			status_flags_register_q <= status_flags_register_d;
			sp_q <= sp_d;
			tgt_q <= tgt_d;
			ir_q <= ir_d;
		end
	end

	// Working registers hold data only, so they are left out of reset.
	always_ff @(posedge sys_clk)
	begin
		if (ce && we1)
			rf_q[wa1] <= wd1;
		if (ce && we2)
			rf_q[wa2] <= wd2;
	end

	default clocking a_cb @(posedge sys_clk);
	endclocking
	default disable iff (sys_rst || !ce);

	a_alu_one_cycle: assert property ( // RULE1
		(state_q == cie_pkg::ST_EXEC) && fl_arith |=> (state_q == cie_pkg::ST_EXEC)
		&& (pc_q == $past(pc_q) + cie_pkg::ONE_WORD))
		else $error("alu op did not finish in one cycle");
	a_logic_flags: assert property ( // RULE4
		(state_q == cie_pkg::ST_EXEC) && fl_logic |=> !status_flags_register_q[cie_pkg::FLAG_V]
		&& (status_flags_register_q[cie_pkg::FLAG_C] == $past(status_flags_register_q[cie_pkg::FLAG_C])))
		else $error("logic op touched wrong flags");
	a_word_two_cycle: assert property ( // RULE2
		(state_q == cie_pkg::ST_EXEC) && fl_word |=> (state_q == cie_pkg::ST_STALL)
		##1 (state_q == cie_pkg::ST_EXEC))
		else $error("word op not two cycles");
	a_mul_pair: assert property ( // RULE7
		(state_q == cie_pkg::ST_EXEC) && fl_mul |=>
		({rf_q[cie_pkg::REG_R1], rf_q[cie_pkg::REG_R0]} == $past(prod))
		&& (state_q == cie_pkg::ST_STALL))
		else $error("product not in pair one and zero");
	a_pjump_target: assert property ( // RULE9
		(state_q == cie_pkg::ST_EXEC) && (pm_data == cie_pkg::OP_PTR_JUMP) |=>
		(pc_q == $past(zptr)) && $stable(status_flags_register_q))
		else $error("pointer jump target wrong");
	a_pcall_three: assert property ( // RULE10
		(state_q == cie_pkg::ST_EXEC) && (pm_data == cie_pkg::OP_PTR_CALL) |=>
		(state_q == cie_pkg::ST_PUSH) ##1 (state_q == cie_pkg::ST_STALL)
		&& (pc_q == $past(zptr, 2)) ##1 (state_q == cie_pkg::ST_EXEC))
		else $error("pointer call not three cycles");
	a_branch_offset: assert property ( // RULE15
		(state_q == cie_pkg::ST_EXEC) && fl_branch && br_taken |=>
		(pc_q == $past(br_target)) ##1 (state_q == cie_pkg::ST_EXEC))
		else $error("taken branch wrong");
	a_skip_length: assert property ( // RULE24
		(state_q == cie_pkg::ST_SKIP) && cie_pkg::is_two_word(pm_data) |=>
		(state_q == cie_pkg::ST_STALL) && (pc_q == $past(pc_q) + cie_pkg::TWO_WORDS))
		else $error("two-word skip wrong");
	a_bit_write_mask: assert property ( // RULE19
		fl_bitio && dbus_we |-> $onehot(dbus_wmask) && (dbus_addr < cie_pkg::IO_BIT_LIMIT))
		else $error("bit write not single bit in low range");
	a_port_window: assert property ( // RULE20
		fl_port |-> (dbus_addr >= cie_pkg::IO_DATA_OFFSET)
		&& (dbus_addr <= cie_pkg::IO_PORT_LAST))
		else $error("port access outside window");

	c_skip_two: cover property ((state_q == cie_pkg::ST_SKIP) && cie_pkg::is_two_word(pm_data));
	c_pcall: cover property ((state_q == cie_pkg::ST_PUSH) ##1 (state_q == cie_pkg::ST_STALL));
	c_branch: cover property ((state_q == cie_pkg::ST_EXEC) && fl_branch && br_taken);
	c_frac_mul: cover property ((state_q == cie_pkg::ST_EXEC) && fl_mul && mul_fr);
endmodule

//--- cie_mem_model.sv
// Partner model: program ROM and data-space memory facing the execute core.
module cie_mem_model (
	// Clock, reset and enable
	input  wire logic        sys_clk,
	input  wire logic        sys_rst,
	input  wire logic        ce,
	// Program memory
	input  wire logic [15:0] pm_addr,
	output logic [15:0]      pm_data,
	// Data space
	input  wire logic [15:0] dbus_addr,
	input  wire logic        dbus_re,
	input  wire logic        dbus_we,
	input  wire logic [7:0]  dbus_wdata,
	input  wire logic [7:0]  dbus_wmask,
	output logic [7:0]       dbus_rdata
);
	timeunit 1ns;
	timeprecision 1ns;

	logic [15:0] rom [0:255];
	logic [7:0]  mem [0:255];
	logic [7:0]  old;

	// A no-op is shown while reset is held so that no stray access is decoded.
	assign pm_data = sys_rst ? 16'h0000 : rom[pm_addr[7:0]];
	// An unselected data line toggles each half cycle instead of holding a stale byte.
	assign dbus_rdata = dbus_re ? mem[dbus_addr[7:0]] : (8'hA5 ^ {8{sys_clk}});
	assign old = mem[dbus_addr[7:0]];

	always @(posedge sys_clk)
	begin
		if (ce && dbus_we)
		begin
			mem[dbus_addr[7:0]] <= (old & ~dbus_wmask) | (dbus_wdata & dbus_wmask);
		end
	end
endmodule

//--- tb.sv
// Self-checking bench: runs short programs on the execute core and checks results.
module tb;
	timeunit 1ns;
	timeprecision 1ns;

	typedef struct packed {
		logic [15:0] op;
		logic [7:0]  a;
		logic [7:0]  b;
		logic [7:0]  lo;
		logic [7:0]  hi;
		logic [7:0]  fl;
		logic        mul;
	} cie_tv_s;

	logic        sys_clk;
	logic        sys_rst;
	logic        ce;
	logic [15:0] pm_addr;
	logic [15:0] pm_data;
	logic [15:0] dbus_addr;
	logic        dbus_re;
	logic        dbus_we;
	logic [7:0]  dbus_wdata;
	logic [7:0]  dbus_wmask;
	logic [7:0]  dbus_rdata;
	logic [7:0]  status_flags;
	int          n_errors;
	int          cmp_count;

	cie_core #(.LARGE_PM(1'b1), .SP_INIT(cie_pkg::SP_RESET)) u_dut (
		.sys_clk(sys_clk), .sys_rst(sys_rst), .ce(ce), .pm_addr(pm_addr), .pm_data(pm_data),
		.dbus_addr(dbus_addr), .dbus_re(dbus_re), .dbus_we(dbus_we), .dbus_wdata(dbus_wdata),
		.dbus_wmask(dbus_wmask), .dbus_rdata(dbus_rdata), .status_flags(status_flags)
	);

	cie_mem_model u_mem (
		.sys_clk(sys_clk), .sys_rst(sys_rst), .ce(ce), .pm_addr(pm_addr), .pm_data(pm_data),
		.dbus_addr(dbus_addr), .dbus_re(dbus_re), .dbus_we(dbus_we), .dbus_wdata(dbus_wdata),
		.dbus_wmask(dbus_wmask), .dbus_rdata(dbus_rdata)
	);

	initial
	begin
		sys_clk = 1'b0;
		forever #25 sys_clk = ~sys_clk;
	end

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			n_errors++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic report_and_stop();
		$display("compares=%0d errors=%0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// Loads a program under reset, runs it to endpc, then checks cycles, bytes and flags.
	task automatic exec(input logic [15:0] prog[$], input logic [7:0] init05, input int endpc,
		input int cyc, input logic [7:0] e05, input logic [7:0] e06, input logic [7:0] efl);
		int n;
		sys_rst <= 1'b1;
		repeat (5) @(posedge sys_clk);
		for (int i = 0; i < 256; i++)
		begin
			u_mem.rom[i] = (i < prog.size()) ? prog[i] : 16'h0000;
			u_mem.mem[i] = 8'h00;
		end
		u_mem.mem[8'h25] = init05;
		sys_rst <= 1'b0;
		n = 0;
		while (pm_addr !== 16'(endpc) && n < 100)
		begin
			@(posedge sys_clk);
			#1;
			n++;
		end
		chk(16'(n), 16'(cyc));
		chk({8'h00, u_mem.mem[8'h25]}, {8'h00, e05});
		chk({8'h00, u_mem.mem[8'h26]}, {8'h00, e06});
		chk({8'h00, status_flags}, {8'h00, efl});
	endtask

	// Carry is preset, so flags that an operation must leave alone show up as kept.
	task automatic t_alu();
		cie_tv_s tv [19];
		tv = '{'{16'h0F01, 8'h8F, 8'h71, 8'h00, 8'h71, 8'h23, 1'b0},
			'{16'h1F01, 8'h7F, 8'h00, 8'h80, 8'h00, 8'h2C, 1'b0},
			'{16'h1B01, 8'h10, 8'h20, 8'hF0, 8'h20, 8'h15, 1'b0},
			'{16'h0B01, 8'h80, 8'h00, 8'h7F, 8'h00, 8'h38, 1'b0},
			'{16'h5001, 8'h01, 8'h55, 8'h00, 8'h55, 8'h02, 1'b0},
			'{16'h2301, 8'hF0, 8'h3C, 8'h30, 8'h3C, 8'h01, 1'b0},
			'{16'h2B01, 8'h80, 8'h01, 8'h81, 8'h01, 8'h15, 1'b0},
			'{16'h2701, 8'h5A, 8'h5A, 8'h00, 8'h5A, 8'h03, 1'b0},
			'{16'h600F, 8'h80, 8'h11, 8'h8F, 8'h11, 8'h15, 1'b0},
			'{16'h700F, 8'hF3, 8'h22, 8'h03, 8'h22, 8'h01, 1'b0},
			'{16'h2300, 8'h00, 8'h33, 8'h00, 8'h33, 8'h03, 1'b0},
			'{16'h3401, 8'h40, 8'h44, 8'h40, 8'h44, 8'h35, 1'b0},
			'{16'h9F01, 8'hFF, 8'h80, 8'h80, 8'h7F, 8'h00, 1'b1},
			'{16'h0201, 8'hFF, 8'h80, 8'h80, 8'h00, 8'h00, 1'b1},
			'{16'h0301, 8'hFF, 8'h80, 8'h80, 8'hFF, 8'h01, 1'b1},
			'{16'h0309, 8'hFF, 8'h80, 8'h00, 8'hFF, 8'h00, 1'b1},
			'{16'h0381, 8'hFF, 8'h80, 8'h00, 8'h01, 8'h00, 1'b1},
			'{16'h0389, 8'hFF, 8'h80, 8'h00, 8'hFF, 8'h01, 1'b1},
			'{16'h0F01, 8'h01, 8'h02, 8'h03, 8'h02, 8'h00, 1'b0}};
		foreach (tv[i])
			exec('{16'hE120, 16'h3A20, {4'hE, tv[i].a[7:4], 4'h0, tv[i].a[3:0]},
				{4'hE, tv[i].b[7:4], 4'h1, tv[i].b[3:0]}, tv[i].op,
				tv[i].mul ? 16'hB805 : 16'hB905, tv[i].mul ? 16'hB816 : 16'hB916},
				8'h00, 7, tv[i].mul ? 8 : 7, tv[i].lo, tv[i].hi, tv[i].fl);
		$display("t_alu done");
	endtask

	task automatic t_word();
		exec('{16'hEF8F, 16'hE79F, 16'h9601, 16'hB985, 16'hB996}, 8'h00, 5, 6, 8'h00, 8'h80, 8'h0C);
		exec('{16'hE080, 16'hE090, 16'h9701, 16'hB985, 16'hB996}, 8'h00, 5, 6, 8'hFF, 8'hFF, 8'h15);
		$display("t_word done");
	endtask

	task automatic t_branch();
		logic [15:0] br [4];
		br = '{16'hF40C, 16'hF00C, 16'hF008, 16'hF408};
		for (int i = 0; i < 4; i += 2)
			exec('{16'hE111, 16'hE800, 16'h3001, br[i], br[i + 1], 16'hEA1A, 16'hB916},
				8'h00, 7, 7, 8'h00, 8'h11, 8'h38);
		$display("t_branch done");
	endtask

	task automatic t_skip();
		exec('{16'hE50A, 16'hE51A, 16'h1301, 16'h9300, 16'h0025, 16'hFF01, 16'hE010,
			16'hFD02, 16'hE010, 16'h9B28, 16'hB916, 16'h9928, 16'hB905},
			8'h00, 13, 13, 8'h00, 8'h5A, 8'h00);
		$display("t_skip done");
	endtask

	// Only ports 0x05, 0x06 and data 0x60 are written, none of them reserved.
	task automatic t_iobit();
		exec('{16'h9A29, 16'h982F, 16'hB105, 16'hB906, 16'h9110, 16'h0026, 16'h9310, 16'h0060},
			8'hA5, 8, 10, 8'h27, 8'h27, 8'h00);
		chk({8'h00, u_mem.mem[8'h60]}, 16'h0027);
		$display("t_iobit done");
	endtask

	task automatic t_ptr();
		exec('{16'hE0E8, 16'h39E8, 16'hE0F0, 16'h9509, 16'hB9E5, 16'h0000, 16'h0000, 16'h0000,
			16'hE0EC, 16'h9409, 16'hB9E5, 16'h0000, 16'hB9E5}, 8'h00, 13, 10, 8'h0C, 8'h00, 8'h01);
		chk({8'h00, u_mem.mem[8'hFF]}, 16'h0004);
		chk({8'h00, u_mem.mem[8'hFE]}, 16'h0000);
		exec('{16'hE30C, 16'h940C, 16'h0004, 16'hE000, 16'hB905}, 8'h00, 5, 5, 8'h3C, 8'h00, 8'h00);
		$display("t_ptr done");
	endtask

	initial
	begin
		sys_rst = 1'b1;
		ce = 1'b1;
		n_errors = 0;
		cmp_count = 0;
		t_alu();
		t_word();
		t_branch();
		t_skip();
		t_iobit();
		t_ptr();
		report_and_stop();
	end

	// About 340 cycles are needed; the limit leaves a wide margin.
	initial
	begin
		#200000;
		n_errors++;
		report_and_stop();
	end
endmodule
